//--- inc/lclc_pkg.sv
// Shared constants and carrier types for the line code and loss channel
`default_nettype none
package lclc_pkg;
    // ------------------------------------------------------------
    // Register map and control layout
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_CTRL  = 32'h0000_0000; // Control word
    localparam logic [31:0] ADDR_STAT  = 32'h0000_0004; // Status word
    localparam logic [8:0]  CTRL_RESET = 9'h000;        // Control reset value
    localparam int          CTRL_W     = 9;             // Control bits used
    localparam logic [2:0]  STAT_RESET = 3'h0;          // Status reset value

    // Rate codes held in the control word
    localparam logic [1:0] RATE_DS3  = 2'h0;
    localparam logic [1:0] RATE_STS1 = 2'h1;
    localparam logic [1:0] RATE_E3   = 2'h2;

    // Transmit buffer symbol codes
    localparam logic [1:0] SYM_ZERO = 2'h0; // Plain zero
    localparam logic [1:0] SYM_MARK = 2'h1; // Ordinary or B pulse
    localparam logic [1:0] SYM_SUBZ = 2'h2; // Zero taken by a substitution
    localparam logic [1:0] SYM_VIOL = 2'h3; // Violation pulse

    // ------------------------------------------------------------
    // Loss detection counts, in line symbols
    // ------------------------------------------------------------
    localparam logic [7:0] DS3_DECL    = 8'haf; // Zero run to declare, 175
    localparam logic [7:0] DS3_WIN     = 8'haf; // Density window, 175
    localparam logic [7:0] DS3_ONES    = 8'h3a; // Above 33 percent of 175
    localparam logic [7:0] E3_DECL_DEF = 8'h20; // Zero run to declare
    localparam logic [7:0] E3_CLR_DEF  = 8'h20; // Restored symbols to clear
    localparam logic [7:0] E3_GAP_MAX  = 8'h04; // Shortest gap that ends restore
    localparam logic [7:0] RUN_B3ZS    = 8'h02; // Third zero lands on this
    localparam logic [7:0] RUN_HDB3    = 8'h03; // Fourth zero lands on this
    localparam logic [7:0] RUN_MAX     = 8'hff; // Zero run saturation

    // Control word
    typedef struct packed {
        logic       build_out_select; // 1 disables build-out
        logic       monitor;          // Receive monitor mode
        logic       digital_loss_condition_dis;         // Digital loss disable, takes effect only with analog disable also set
        logic       analog_loss_condition_dis;         // Analog loss disable, takes effect only with digital disable also set
        logic       mute;             // Loss mute enable
        logic       tx_fall;          // Sample transmit on falling edge
        logic       dual_rail;        // Codec bypass
        logic [1:0] rate;             // Rate select
    } lclc_ctrl_t;

    // Status word
    typedef struct packed {
        logic combined_receive_loss; // Combined receive loss
        logic analog_loss_condition; // Analog loss status
        logic digital_loss_condition; // Digital loss status
    } lclc_stat_t;

    // Pins from outside the clock domain
    typedef struct packed {
        logic rx_clk;
        logic ref_clk;
        logic rx_pos;
        logic rx_neg;
        logic aloss;
        logic tx_clk;
        logic tx_pos;
        logic tx_neg;
    } lclc_pins_t;
endpackage
`default_nettype wire

//--- hdl/lclc_channel.sv
// One line interface channel: loss detection, codec and register slave
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - DS3/STS-1: 175 zeros declare digital loss
// - Digital loss clears above 33% density
// - Analog loss pin mirrored to status
// - Combined loss is digital OR analog
// - Combined loss drives pin and status
// - Both disable bits stop loss detection
// - E3: zero run of 10..255 declares
// - E3: clears 10..255 UI after restore
// - Reference clock replaces recovered during loss
// - Mute and loss force rails zero
// - Loss clear resumes recovered data
// - Decoder strips B3ZS or HDB3 substitutions
// - Violation pulse on bad BPV, zeros
// - Transmit sample edge is selectable
// - Encoder only in single-rail mode
// - Dual-rail bypasses encoder and decoder
// - Ordinary marks alternate polarity
// - B3ZS: 00V or B0V, odd pulses
// - HDB3: 000V or B00V, odd pulses
// - Build-out follows bit, off in E3
// - Monitor mode suppresses loss
module lclc_channel #(
    parameter logic [7:0] E3_DECL = lclc_pkg::E3_DECL_DEF, // E3 declare run
    parameter logic [7:0] E3_CLR  = lclc_pkg::E3_CLR_DEF   // E3 clear run
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        rx_line_clk,
    input  wire logic        ref_clk,
    input  wire logic        rx_line_pos,
    input  wire logic        rx_line_neg,
    input  wire logic        analog_loss_in,
    input  wire logic        transmit_clock_input,
    input  wire logic        transmit_positive_rail,
    input  wire logic        transmit_negative_rail,
    output logic             receive_clock_output,
    output logic             receive_positive_rail,
    output logic             receive_negative_rail,
    output logic             line_code_violation_output,
    output logic             receive_loss_output,
    output logic             tx_line_pos,
    output logic             tx_line_neg,
    output logic             build_out_enable
);
    import lclc_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers and edge finders
    // ------------------------------------------------------------
    lclc_pins_t pins_raw;   // Raw pins
    lclc_pins_t pin_meta_r; // First stage, read by second only
    lclc_pins_t pin_sync_r; // Second stage
    lclc_pins_t pin_last_r; // Previous synced value
    lclc_ctrl_t ctrl_r;     // Control register
    logic       rx_edge;    // Recovered clock rising
    logic       tx_edge;    // Selected transmit clock edge

    assign pins_raw = '{rx_clk: rx_line_clk, ref_clk: ref_clk,
                        rx_pos: rx_line_pos, rx_neg: rx_line_neg,
                        aloss: analog_loss_in, tx_clk: transmit_clock_input,
                        tx_pos: transmit_positive_rail,
                        tx_neg: transmit_negative_rail};

    // Two flip-flops on every pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= pins_raw;
            pin_sync_r <= pin_meta_r;
        end
    end

    // History for edge detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_last_r <= '0;
        end else begin
            pin_last_r <= pin_sync_r;
        end
    end

    assign rx_edge = pin_sync_r.rx_clk & ~pin_last_r.rx_clk;
    // Sample edge chosen by control
    assign tx_edge = ctrl_r.tx_fall ? (~pin_sync_r.tx_clk & pin_last_r.tx_clk)
                                    : (pin_sync_r.tx_clk & ~pin_last_r.tx_clk);

    // ------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------
    lclc_stat_t stat;       // Live status
    logic       wr_pend_r;  // Write data phase due
    logic [31:0] wr_addr_r; // Write address
    logic       ctrl_wr;    // Control written this cycle
    logic       rd_req;     // Read address phase taken
    lclc_ctrl_t ctrl_view;  // Control as a read sees it

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign ctrl_wr   = wr_pend_r && (wr_addr_r == ADDR_CTRL);
    assign rd_req    = hsel && hready && htrans[1] && !hwrite;
    assign ctrl_view = ctrl_wr ? lclc_ctrl_t'(hwdata[CTRL_W-1:0]) : ctrl_r;

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end else if (hready) begin
            wr_pend_r <= hsel && htrans[1] && hwrite;
            wr_addr_r <= {haddr[31:2], 2'b00};
        end
    end

    // Control register write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= lclc_ctrl_t'(CTRL_RESET);
        end else if (ctrl_wr) begin
            ctrl_r <= lclc_ctrl_t'(hwdata[CTRL_W-1:0]);
        end
    end

    // Read data, unmapped reads as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (rd_req) begin
            if ({haddr[31:2], 2'b00} == ADDR_CTRL) begin
                hrdata <= {{(32-CTRL_W){1'b0}}, ctrl_view};
            end else if ({haddr[31:2], 2'b00} == ADDR_STAT) begin
                hrdata <= {29'h0000_000, stat};
            end else begin
                hrdata <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Receive decoder
    // ------------------------------------------------------------
    logic       e3;          // E3 rate selected
    logic [1:0] rate_prev_r; // Rate seen last cycle
    logic       rate_chg;    // Rate just changed
    logic       rx_mark;     // Pulse on either rail
    logic       rx_negp;     // Pulse is negative
    logic       rx_both;     // Both rails high, illegal
    logic       seen_r;      // A pulse was seen
    logic       last_neg_r;  // Polarity of last pulse
    logic       bpv;         // Same polarity twice
    logic       legal_v;     // Violation that ends a substitution
    logic [3:0] win_r;       // Decoded marks awaiting output
    logic [3:0] win_nxt;
    logic [7:0] zrun_r;      // Zeros since last pulse
    logic [7:0] zrun_nxt;
    logic       lcv_hit;     // Violation found on this symbol
    logic       dat_pos_r;   // Receive data before muting
    logic       dat_neg_r;

    assign e3       = (ctrl_r.rate == RATE_E3);
    assign rate_chg = (rate_prev_r != ctrl_r.rate);
    assign rx_mark  = pin_sync_r.rx_pos | pin_sync_r.rx_neg;
    assign rx_negp  = pin_sync_r.rx_neg & ~pin_sync_r.rx_pos;
    assign rx_both  = pin_sync_r.rx_pos & pin_sync_r.rx_neg;
    assign bpv      = rx_mark & seen_r & (rx_negp == last_neg_r);
    // Zeros must precede V in the substitution slot
    assign legal_v  = bpv & (e3 ? (win_r[1:0] == 2'b00) : ~win_r[0]);
    assign zrun_nxt = rx_mark ? 8'h00 : ((zrun_r == RUN_MAX) ? RUN_MAX : zrun_r + 8'h01);
    // Bad BPV or excessive zeros
    assign lcv_hit  = (bpv & ~legal_v) | rx_both |
                      (~rx_mark & (zrun_r == (e3 ? RUN_HDB3 : RUN_B3ZS)));

    // Window shift, substitution pulses wiped
    always_comb begin
        win_nxt = {win_r[2:0], rx_mark & ~legal_v};
        if (legal_v) begin
            win_nxt[1] = 1'b0;
            win_nxt[2] = 1'b0;
            if (e3) begin
                win_nxt[3] = 1'b0;
            end
        end
    end

    // Rate history
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_prev_r <= RATE_DS3;
        end else begin
            rate_prev_r <= ctrl_r.rate;
        end
    end

    // Decoder state advances on recovered clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win_r      <= '0;
            seen_r     <= 1'b0;
            last_neg_r <= 1'b0;
            dat_pos_r  <= 1'b0;
            dat_neg_r  <= 1'b0;
            line_code_violation_output <= 1'b0;
        end else if (rx_edge) begin
            win_r <= win_nxt;
            if (rx_mark) begin
                seen_r     <= 1'b1;
                last_neg_r <= rx_negp;
            end
            if (ctrl_r.dual_rail) begin // Decoder bypass
                dat_pos_r <= pin_sync_r.rx_pos;
                dat_neg_r <= pin_sync_r.rx_neg;
                line_code_violation_output <= 1'b0;
            end else begin
                dat_pos_r <= e3 ? win_nxt[3] : win_nxt[2];
                dat_neg_r <= 1'b0;
                line_code_violation_output <= lcv_hit;
            end
        end
    end

    // ------------------------------------------------------------
    // Loss detection
    // ------------------------------------------------------------
    logic       det_off;    // Detection suppressed
    logic       dloss_r;    // Digital loss condition
    logic       aloss;      // Analog loss condition
    logic       combined_receive_loss;       // Combined receive loss
    logic [7:0] dwin_r;     // Density window position
    logic [7:0] ones_r;     // Pulses in window
    logic [7:0] ones_nxt;
    logic [7:0] rest_r;     // Restored symbols in E3
    logic       dwin_end;   // Last symbol of window

    // Both disables, or monitor mode
    assign det_off  = (ctrl_r.analog_loss_condition_dis & ctrl_r.digital_loss_condition_dis) | ctrl_r.monitor;
    assign aloss    = pin_sync_r.aloss;
    assign combined_receive_loss     = (dloss_r | aloss) & ~det_off;
    assign ones_nxt = ones_r + {7'h00, rx_mark};
    assign dwin_end = (dwin_r == DS3_WIN - 8'h01);
    assign stat     = '{combined_receive_loss: combined_receive_loss, analog_loss_condition: aloss, digital_loss_condition: dloss_r};
    assign receive_loss_output = combined_receive_loss;

    // Zero run and density counters, cleared on rate change
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            zrun_r <= '0;
            dwin_r <= '0;
            ones_r <= '0;
            rest_r <= '0;
        end else if (rate_chg) begin
            zrun_r <= '0;
            dwin_r <= '0;
            ones_r <= '0;
            rest_r <= '0;
        end else if (rx_edge) begin
            zrun_r <= zrun_nxt;
            dwin_r <= (!dloss_r || dwin_end) ? 8'h00 : dwin_r + 8'h01;
            ones_r <= (!dloss_r || dwin_end) ? 8'h00 : ones_nxt;
            rest_r <= (dloss_r && zrun_nxt < E3_GAP_MAX) ? rest_r + 8'h01 : 8'h00;
        end
    end

    // Declare and clear digital loss per rate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dloss_r <= 1'b0;
        end else if (det_off || rate_chg) begin
            dloss_r <= 1'b0;
        end else if (rx_edge) begin
            if (!dloss_r) begin
                if (!rx_mark && zrun_r == (e3 ? E3_DECL : DS3_DECL) - 8'h01) begin
                    dloss_r <= 1'b1;
                end
            end else if (e3) begin
                if (rest_r == E3_CLR - 8'h01 && zrun_nxt < E3_GAP_MAX) begin
                    dloss_r <= 1'b0;
                end
            end else if (dwin_end && ones_nxt >= DS3_ONES) begin
                dloss_r <= 1'b0;
            end
        end
    end

    // Clock substitution and data mute
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            receive_clock_output  <= 1'b0;
            receive_positive_rail <= 1'b0;
            receive_negative_rail <= 1'b0;
        end else begin
            receive_clock_output <= combined_receive_loss ? pin_sync_r.ref_clk : pin_sync_r.rx_clk;
            if (combined_receive_loss && ctrl_r.mute) begin
                receive_positive_rail <= 1'b0;
                receive_negative_rail <= 1'b0;
            end else begin
                receive_positive_rail <= dat_pos_r;
                receive_negative_rail <= dat_neg_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit encoder
    // ------------------------------------------------------------
    logic [3:0][1:0] tbuf_r;    // Symbols awaiting polarity
    logic [3:0][1:0] tbuf_nxt;
    logic            par_r;     // Pulses since last V are odd
    logic            tlast_r;   // Last line pulse was negative
    logic            in_bit;    // Sampled data bit
    logic            grp;       // Zero group completes
    logic [1:0]      sym;       // Symbol leaving the buffer
    logic            sym_neg;   // Its polarity

    assign in_bit  = pin_sync_r.tx_pos;
    assign grp     = ~in_bit & (tbuf_r[0] == SYM_ZERO) & (tbuf_r[1] == SYM_ZERO) &
                     (~e3 | (tbuf_r[2] == SYM_ZERO));
    assign sym     = e3 ? tbuf_r[3] : tbuf_r[2];
    // Marks alternate, V repeats last polarity
    assign sym_neg = (sym == SYM_VIOL) ? tlast_r : ~tlast_r;

    // Substitution of a zero group
    always_comb begin
        tbuf_nxt    = {tbuf_r[2:0], (in_bit ? SYM_MARK : SYM_ZERO)};
        if (grp) begin
            tbuf_nxt[0] = SYM_VIOL;
            tbuf_nxt[1] = SYM_SUBZ;
            if (e3) begin // 000V or B00V
                tbuf_nxt[2] = SYM_SUBZ;
                tbuf_nxt[3] = par_r ? SYM_SUBZ : SYM_MARK;
            end else begin // 00V or B0V
                tbuf_nxt[2] = par_r ? SYM_SUBZ : SYM_MARK;
            end
        end
    end

    // Encoder state and line rails
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tbuf_r      <= '0;
            par_r       <= 1'b0;
            tlast_r     <= 1'b0;
            tx_line_pos <= 1'b0;
            tx_line_neg <= 1'b0;
        end else if (tx_edge) begin
            if (ctrl_r.dual_rail) begin // Encoder bypass
                tx_line_pos <= pin_sync_r.tx_pos;
                tx_line_neg <= pin_sync_r.tx_neg;
            end else begin // Single rail only
                tbuf_r <= tbuf_nxt;
                par_r  <= grp ? 1'b0 : (par_r ^ in_bit);
                if (sym == SYM_MARK || sym == SYM_VIOL) begin
                    tlast_r     <= sym_neg;
                    tx_line_pos <= ~sym_neg;
                    tx_line_neg <= sym_neg;
                end else begin
                    tx_line_pos <= 1'b0;
                    tx_line_neg <= 1'b0;
                end
            end
        end
    end

    // Build-out enable, never in E3
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            build_out_enable <= 1'b0;
        end else begin
            build_out_enable <= ~e3 & ~ctrl_r.build_out_select;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_dloss_ds3_decl: assert property (
        rx_edge && !e3 && !det_off && !rate_chg && !dloss_r && !rx_mark &&
        zrun_r == DS3_DECL - 8'h01 |=> dloss_r && stat.digital_loss_condition)
        else $error("digital loss not declared after zero run");
    a_dloss_ds3_clr: assert property (
        rx_edge && !e3 && dloss_r && !det_off && !rate_chg && dwin_end &&
        ones_nxt >= DS3_ONES |=> !dloss_r)
        else $error("digital loss not cleared by density");
    a_aloss_status: assert property (
        $rose(analog_loss_in) |=> ##[1:2] stat.analog_loss_condition)
        else $error("analog loss status late");
    a_loss_pin_or: assert property (
        (dloss_r || pin_sync_r.aloss) && !det_off |-> receive_loss_output)
        else $error("loss pin missing");
    a_detect_off: assert property (
        det_off |-> !receive_loss_output ##1 !dloss_r)
        else $error("loss raised while disabled");
    a_e3_decl_run: assert property (
        rx_edge && e3 && !det_off && !rate_chg && !dloss_r && !rx_mark &&
        zrun_r == E3_DECL - 8'h01 |=> dloss_r)
        else $error("E3 loss not declared");
    a_ref_clock_sub: assert property (
        receive_loss_output |=> receive_clock_output == $past(pin_sync_r.ref_clk))
        else $error("reference clock not substituted");
    a_mute_rails: assert property (
        receive_loss_output && ctrl_r.mute |=>
            !receive_positive_rail && !receive_negative_rail)
        else $error("rails not muted");
    a_lcv_run: assert property (
        rx_edge && !ctrl_r.dual_rail && !rx_mark && zrun_r == RUN_B3ZS && !e3
        |=> line_code_violation_output)
        else $error("excess zeros not flagged");
    a_tx_rails_excl: assert property (
        !ctrl_r.dual_rail |-> !(tx_line_pos && tx_line_neg))
        else $error("both transmit rails high");
    a_buildout_e3: assert property (
        e3 ##1 e3 |-> !build_out_enable)
        else $error("build-out enabled in E3");

    c_dloss_decl: cover property (rx_edge && !e3 ##1 $rose(dloss_r));
    c_e3_clear:   cover property (e3 && $fell(dloss_r));
    c_tx_viol:    cover property (tx_edge && !ctrl_r.dual_rail && sym == SYM_VIOL);
    c_legal_v:    cover property (rx_edge && legal_v);
endmodule // lclc_channel
`default_nettype wire

//--- verif/lclc_line_model.sv
// Far-side model: line and transmit clock plus data rails
`timescale 1ns/1ps
`default_nettype none
module lclc_line_model (
    input  wire logic run,   // Clock runs while high
    input  wire logic pos,   // Next positive rail symbol
    input  wire logic neg,   // Next negative rail symbol
    output logic      lclk,  // Shared line clock, 125 ns
    output logic      l_pos, // Positive rail to the block
    output logic      l_neg  // Negative rail to the block
);
    // ------------------------------------------------------------
    // Clock stands low when stopped; rails launch on the falling edge
    // ------------------------------------------------------------
    initial begin
        lclk = 1'b0;
        l_pos = 1'b0;
        l_neg = 1'b0;
    end
    always #62.5 lclk = run ? ~lclk : 1'b0;
    always @(negedge lclk) begin
        l_pos <= pos;
        l_neg <= neg;
    end
endmodule // lclc_line_model
`default_nettype wire

//--- verif/lclc_channel_tb.sv
// Self-checking bench for the line code and loss channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module lclc_channel_tb;
    import lclc_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ref_clk = 0, aloss = 0;
    logic run = 0, pos = 0, neg = 0, seen, lclk, l_pos, l_neg;
    logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
    logic [1:0]  htrans = 0, p1, p2;
    logic hreadyout, hresp, rxc, pr, rpos, rneg, lcv, combined_receive_loss, tpos, tneg, boe;
    int n_errors = 0, samples_checked = 0, cyc = 0, t;
    always #5 hclk = ~hclk;
    always #50 ref_clk = ~ref_clk;
    lclc_line_model lclc_line_model_inst (.run(run), .pos(pos), .neg(neg), .lclk(lclk),
        .l_pos(l_pos), .l_neg(l_neg));
    lclc_channel #(.E3_DECL(8'h0a), .E3_CLR(8'h0a)) lclc_channel_inst (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .rx_line_clk(lclk), .ref_clk(ref_clk),
        .rx_line_pos(l_pos), .rx_line_neg(l_neg), .analog_loss_in(aloss),
        .transmit_clock_input(lclk), .transmit_positive_rail(l_pos),
        .transmit_negative_rail(l_neg), .receive_clock_output(rxc),
        .receive_positive_rail(rpos), .receive_negative_rail(rneg),
        .line_code_violation_output(lcv), .receive_loss_output(combined_receive_loss), .tx_line_pos(tpos),
        .tx_line_neg(tneg), .build_out_enable(boe));
    // Single AHB transfer; read data taken at the end of the data phase
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Status word and loss pin after the synchronisers settle
    task automatic stat(input logic [2:0] ex);
        repeat (10) @(posedge hclk);
        bus(1'b0, ADDR_STAT, 32'h0000_0000);
        `CHK("status", {29'h0, ex}, rd)
        `CHK("loss pin", ex[2], combined_receive_loss)
    endtask
    // Send cnt symbols, swapping polarity each symbol when alt is set
    task automatic line(input logic p, input logic n, input logic alt, input int cnt);
        repeat (cnt) begin
            @(posedge lclk);
            pos <= p;
            neg <= n;
            if (alt) {p, n} = {n, p};
        end
        @(posedge hclk);
    endtask
    task stop_test;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1;
        run <= 1;
        hsel <= 1;
        bus(1'b0, ADDR_CTRL, 32'h0000_0000);
        `CHK("ctrl reset", 32'h0000_0000, rd)
        `CHK("build out", 1'b1, boe)
        bus(1'b0, 32'h0000_0010, 32'h0000_0000);
        `CHK("unmapped", 32'h0000_0000, rd)
        bus(1'b1, ADDR_CTRL, 32'h0000_0100);
        bus(1'b0, ADDR_CTRL, 32'h0000_0000);
        `CHK("ctrl", 32'h0000_0100, rd)
        `CHK("build out", 1'b0, boe)
        bus(1'b1, ADDR_CTRL, 32'h0000_0002);
        bus(1'b0, ADDR_CTRL, 32'h0000_0000);
        `CHK("e3 build out", 1'b0, boe)
        line(1'b0, 1'b0, 1'b0, 20);
        stat(3'b101);
        line(1'b1, 1'b0, 1'b1, 20);
        stat(3'b000);
        bus(1'b1, ADDR_CTRL, 32'h0000_0010);
        line(1'b0, 1'b0, 1'b0, 200);
        stat(3'b101);
        t = 0;
        pr = rxc;
        repeat (100) begin
            @(posedge hclk);
            t += (rxc != pr);
            pr = rxc;
        end
        `CHK("ref clock", 1'b1, t inside {[19:21]})
        line(1'b1, 1'b0, 1'b1, 40);
        `CHK("muted", 2'b00, {rpos, rneg})
        line(1'b1, 1'b0, 1'b1, 200);
        `CHK("resumed", 2'b10, {rpos, rneg})
        stat(3'b000);
        aloss <= 1;
        stat(3'b110);
        bus(1'b1, ADDR_CTRL, 32'h0000_0070);
        stat(3'b010);
        bus(1'b1, ADDR_CTRL, 32'h0000_0090);
        stat(3'b010);
        aloss <= 0;
        bus(1'b1, ADDR_CTRL, 32'h0000_0000);
        line(1'b1, 1'b0, 1'b1, 30);
        // Legal 00V groups decode to one mark in four and raise no violation
        seen = 0;
        t = 0;
        fork
            repeat (8) begin
                line(1'b1, 1'b0, 1'b0, 1);
                line(1'b0, 1'b0, 1'b0, 2);
                line(1'b1, 1'b0, 1'b0, 1);
                line(1'b0, 1'b1, 1'b0, 1);
                line(1'b0, 1'b0, 1'b0, 2);
                line(1'b0, 1'b1, 1'b0, 1);
            end
            begin
                repeat (100) @(posedge hclk);
                repeat (400) begin
                    @(posedge hclk);
                    seen |= lcv;
                    t += rpos;
                end
            end
        join
        `CHK("legal v", 1'b0, seen)
        `CHK("decoded", 1'b1, t inside {[88:112]})
        seen = 0;
        fork
            line(1'b1, 1'b1, 1'b0, 2);
            repeat (80) begin
                @(posedge hclk);
                seen |= lcv;
            end
        join
        `CHK("violation", 1'b1, seen)
        line(1'b1, 1'b0, 1'b0, 10);
        @(negedge lclk) p1 = {tpos, tneg};
        @(negedge lclk) p2 = {tpos, tneg};
        `CHK("ami", 2'b11, p1 ^ p2)
        @(posedge hclk);
        bus(1'b1, ADDR_CTRL, 32'h0000_000c);
        line(1'b1, 1'b0, 1'b0, 4);
        `CHK("rx dual", 2'b10, {rpos, rneg})
        `CHK("tx dual", 2'b10, {tpos, tneg})
        line(1'b0, 1'b1, 1'b0, 4);
        `CHK("rx dual", 2'b01, {rpos, rneg})
        `CHK("tx dual", 2'b01, {tpos, tneg})
        stop_test();
    end
endmodule // lclc_channel_tb
`default_nettype wire
